// >>> src/fzr_pkg.sv
// Purpose: shared constants and types of the function 0 register space
// Assumes: 40 MHz core clock
// Notes: addresses are byte addresses of the 128K function space
package fzr_pkg;
	localparam int unsigned CLK_KHZ = 40000;
	localparam int unsigned READY_TO_MS = 1000;
	localparam int unsigned READY_TO_CYC = READY_TO_MS * CLK_KHZ;
	localparam int unsigned NFN = 7;
	// function 0 region map
	localparam logic [16:0] CCCR_LAST = 17'h000ff;
	localparam logic [16:0] FBR_LAST = 17'h007ff;
	localparam logic [16:0] GI_BASE = 17'h00800;
	localparam logic [16:0] GI_LAST = 17'h00bff;
	localparam logic [16:0] CIS_BASE = 17'h01000;
	localparam logic [16:0] CIS_LAST = 17'h17fff;
	// common control offsets
	localparam logic [7:0] CC_REV = 8'h00;
	localparam logic [7:0] CC_SDREV = 8'h01;
	localparam logic [7:0] CC_IOEN = 8'h02;
	localparam logic [7:0] CC_IORDY = 8'h03;
	localparam logic [7:0] CC_INTEN = 8'h04;
	localparam logic [7:0] CC_ABORT = 8'h06;
	localparam logic [7:0] CC_BUSIF = 8'h07;
	localparam logic [7:0] CC_CAP = 8'h08;
	localparam logic [7:0] CC_CISP0 = 8'h09;
	localparam logic [7:0] CC_CISP1 = 8'h0a;
	localparam logic [7:0] CC_CISP2 = 8'h0b;
	localparam logic [7:0] CC_PWR = 8'h12;
	localparam int unsigned ABORT_RES_BIT = 3;
	localparam logic [7:0] BUSIF_WMASK = 8'h83;
	localparam logic [7:0] PWR_WMASK = 8'h1e;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// software side map
	localparam logic [15:0] AXI_CTRL = 16'h0000;
	localparam logic [15:0] AXI_STAT = 16'h0004;
	localparam logic [15:0] AXI_GI_BASE = 16'h0800;
	localparam logic [15:0] AXI_CIS_BASE = 16'h1000;
	localparam int unsigned ST_PATHERR_BIT = 2;
	localparam int unsigned ST_ORDERR_BIT = 3;
	localparam int unsigned ST_TO_LSB = 9;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic PATH_DIRECT = 1'b0;
	localparam logic PATH_EXT = 1'b1;
	typedef enum logic [2:0] {
		REG_CCCR = 3'h0, REG_FBR = 3'h1, REG_GI = 3'h2, REG_CIS = 3'h3, REG_RSVD = 3'h4
	} fzr_region_t;
	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_FU = 2'h1, ST_RSP = 2'h2} fzr_state_t;
endpackage

// >>> src/fzr_dec_if.sv
// Purpose: address decode carrier between top and decoder
// Assumes: nothing
// Notes: combinational only
`timescale 1ns/1ps
`default_nettype none
interface fzr_dec_if;
	logic [16:0] addr;
	fzr_pkg::fzr_region_t region;
	logic [16:0] off;
	modport dec(input addr, output region, output off);
	modport use_(output addr, input region, input off);
endinterface
`default_nettype wire

// >>> src/fzr_decode.sv
// Purpose: split a function 0 address into region and offset
// Assumes: 17-bit byte address
// Notes: holes decode as reserved
`timescale 1ns/1ps
`default_nettype none
module fzr_decode (
	fzr_dec_if.dec d
);
	always_comb begin
		d.region = fzr_pkg::REG_RSVD;
		d.off = d.addr;
		if (d.addr <= fzr_pkg::CCCR_LAST) begin
			d.region = fzr_pkg::REG_CCCR;
		end else if (d.addr <= fzr_pkg::FBR_LAST) begin
			d.region = fzr_pkg::REG_FBR;
			d.off = {9'h000, d.addr[7:0]};
		end else if (d.addr <= fzr_pkg::GI_LAST) begin
			d.region = fzr_pkg::REG_GI;
			d.off = d.addr - fzr_pkg::GI_BASE;
		end else if (d.addr >= fzr_pkg::CIS_BASE && d.addr <= fzr_pkg::CIS_LAST) begin
			d.region = fzr_pkg::REG_CIS;
			d.off = d.addr - fzr_pkg::CIS_BASE;
		end
	end
endmodule
`default_nettype wire

// >>> src/fzr_ready_timer.sv
// Purpose: per-function ready watchdog
// Assumes: en and rdy are core-clock levels
// Notes: expired holds until the function is ready or disabled
`timescale 1ns/1ps
`default_nettype none
module fzr_ready_timer #(
	parameter int unsigned CYCLES = fzr_pkg::READY_TO_CYC,
	parameter int unsigned NFN = fzr_pkg::NFN
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [NFN:1] en,
	input wire logic [NFN:1] rdy,
	output logic [NFN:1] expired
);
	localparam int CW = $clog2(CYCLES + 1);
	for (genvar i = 1; i <= NFN; i++) begin : g_fn
		logic [CW-1:0] cnt_q;
		logic [CW-1:0] cnt_d;
		always_comb begin
			cnt_d = cnt_q;
			if (!en[i] || rdy[i]) begin
				cnt_d = '0;
			end else if (cnt_q < CW'(CYCLES)) begin
				cnt_d = cnt_q + CW'(1);
			end
		end
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_d;
			end
		end
		assign expired[i] = (cnt_q == CW'(CYCLES));
		property p_exp_cause;
			@(posedge clk) disable iff (!resetn)
			$rose(expired[i]) |-> $past(en[i]) && !$past(rdy[i]);
		endproperty
		a_exp_cause: assert property (p_exp_cause) else $error("ready timeout without cause");
	end
endmodule
`default_nettype wire

// >>> src/fzr_top.sv
// Purpose: card-side function 0 common register space
// Assumes: one command at a time from the card command engine
// Notes: software fills general information and CIS over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module fzr_top #(
	parameter int unsigned READY_TO_CYC = fzr_pkg::READY_TO_CYC,
	parameter int unsigned GI_DEPTH = 1024,
	parameter int unsigned CIS_DEPTH = 256,
	parameter logic [7:0] REV_VAL = 8'h00,
	parameter logic [7:0] SD_REV_VAL = 8'h00,
	parameter logic [7:0] CAP_VAL = 8'h00,
	parameter logic [7:0] FBR_CODE_VAL = 8'h00,
	parameter logic SMPC_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_path,
	input wire logic req_io_space,
	input wire logic req_write,
	input wire logic [2:0] req_fn,
	input wire logic [16:0] req_addr,
	input wire logic [7:0] req_wdata,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic rsp_err,
	output logic fu_req_valid,
	output logic [2:0] fu_fn,
	output logic [16:0] fu_addr,
	output logic fu_write,
	output logic [7:0] fu_wdata,
	input wire logic fu_rsp_valid,
	input wire logic [7:0] fu_rsp_rdata,
	input wire logic [7:1] fn_ready,
	input wire logic switch_func,
	output logic [7:1] io_enable,
	output logic [7:1] fn_abort,
	output logic [1:0] bus_width,
	output logic empc
);
	localparam int GIW = $clog2(GI_DEPTH);
	localparam int CIW = $clog2(CIS_DEPTH);
	fzr_dec_if dif();
	logic [7:0] gi_mem [GI_DEPTH];
	logic [7:0] cis_mem [CIS_DEPTH];
	fzr_pkg::fzr_state_t state_q, state_d;
	logic [7:1] ioen_q, ioen_d, abort_q, abort_d, to_q, to_d, timer_exp;
	logic [7:0] inten_q, inten_d, busif_q, busif_d, pwr_q, pwr_d, rd_byte;
	logic lock_q, lock_d, lpath_q, lpath_d, patherr_q, patherr_d, orderr_q, orderr_d;
	logic [7:0] rsp_rdata_q, rsp_rdata_d, fu_wdata_q, fu_wdata_d;
	logic rsp_err_q, rsp_err_d, fu_write_q, fu_write_d, card_res, patherr_set;
	logic [2:0] fu_fn_q, fu_fn_d;
	logic [16:0] fu_addr_q, fu_addr_d;
	logic accept, path_bad, space_bad, ext;
	logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [15:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, stat_word, stat_clr, axi_rword;
	logic [3:0] wstrb_q, wstrb_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic axi_do_wr, lock_clr, gi_we, cis_we;
	logic [GIW-1:0] gi_widx, gi_ridx;
	logic [CIW-1:0] cis_widx, cis_ridx;

	function automatic logic gi_hit(input logic [15:0] a);
		return a >= fzr_pkg::AXI_GI_BASE && a < fzr_pkg::AXI_GI_BASE + 16'(GI_DEPTH);
	endfunction
	function automatic logic cis_hit(input logic [15:0] a);
		return a >= fzr_pkg::AXI_CIS_BASE && a < fzr_pkg::AXI_CIS_BASE + 16'(CIS_DEPTH);
	endfunction

	assign dif.addr = req_addr;
	fzr_decode u_dec (
		.d(dif.use_)
	);
	fzr_ready_timer #(
		.CYCLES(READY_TO_CYC),
		.NFN(fzr_pkg::NFN)
	) u_tmr (
		.clk(clk),
		.resetn(resetn),
		.en(ioen_q),
		.rdy(fn_ready),
		.expired(timer_exp)
	);

	assign req_ready = (state_q == fzr_pkg::ST_IDLE);
	assign accept = req_valid && req_ready;
	assign ext = (req_path == fzr_pkg::PATH_EXT);
	assign path_bad = lock_q && (req_path != lpath_q);
	assign space_bad = ext && !req_io_space;
	assign rsp_valid = (state_q == fzr_pkg::ST_RSP);
	assign rsp_rdata = rsp_rdata_q;
	assign rsp_err = rsp_err_q;
	assign fu_req_valid = (state_q == fzr_pkg::ST_FU);
	assign fu_fn = fu_fn_q;
	assign fu_addr = fu_addr_q;
	assign fu_write = fu_write_q;
	assign fu_wdata = fu_wdata_q;
	assign io_enable = ioen_q;
	assign fn_abort = abort_q;
	assign bus_width = busif_q[1:0];
	assign empc = pwr_q[1];

	// one byte per request, so block length on the extension path never matters
	always_comb begin
		rd_byte = fzr_pkg::RST_BYTE;
		case (dif.region)
			fzr_pkg::REG_CCCR: begin
				case (req_addr[7:0])
					fzr_pkg::CC_REV: rd_byte = REV_VAL;
					fzr_pkg::CC_SDREV: rd_byte = {4'h0, SD_REV_VAL[3:0]};
					fzr_pkg::CC_IOEN: rd_byte = {ioen_q, 1'b0};
					fzr_pkg::CC_IORDY: rd_byte = {fn_ready & ioen_q, 1'b0};
					fzr_pkg::CC_INTEN: rd_byte = ext ? 8'h00 : inten_q;
					fzr_pkg::CC_BUSIF: rd_byte = busif_q;
					fzr_pkg::CC_CAP: rd_byte = ext ? 8'h00 : CAP_VAL;
					// pointer bytes go out lowest first
					fzr_pkg::CC_CISP0: rd_byte = ext ? 8'h00 : fzr_pkg::CIS_BASE[7:0];
					fzr_pkg::CC_CISP1: rd_byte = ext ? 8'h00 : fzr_pkg::CIS_BASE[15:8];
					fzr_pkg::CC_CISP2: rd_byte = ext ? 8'h00 : {7'h00, fzr_pkg::CIS_BASE[16]};
					fzr_pkg::CC_PWR: rd_byte = pwr_q | {7'h00, SMPC_VAL};
					default: rd_byte = fzr_pkg::RST_BYTE;
				endcase
			end
			fzr_pkg::REG_FBR: rd_byte = (dif.off == 17'h0) ? FBR_CODE_VAL : 8'h00;
			fzr_pkg::REG_GI: rd_byte = gi_mem[dif.off[GIW-1:0]];
			fzr_pkg::REG_CIS: rd_byte = (dif.off < 17'(CIS_DEPTH)) ? cis_mem[dif.off[CIW-1:0]] : 8'h00;
			default: rd_byte = fzr_pkg::RST_BYTE;
		endcase
	end

	always_comb begin
		state_d = state_q;
		ioen_d = ioen_q;
		inten_d = inten_q;
		busif_d = busif_q;
		pwr_d = pwr_q;
		abort_d = '0;
		lock_d = lock_clr ? 1'b0 : lock_q;
		lpath_d = lpath_q;
		rsp_rdata_d = rsp_rdata_q;
		rsp_err_d = rsp_err_q;
		fu_fn_d = fu_fn_q;
		fu_addr_d = fu_addr_q;
		fu_write_d = fu_write_q;
		fu_wdata_d = fu_wdata_q;
		card_res = 1'b0;
		patherr_set = 1'b0;
		case (state_q)
			fzr_pkg::ST_IDLE: begin
				if (accept) begin
					rsp_err_d = 1'b0;
					rsp_rdata_d = 8'h00;
					state_d = fzr_pkg::ST_RSP;
					if (path_bad) begin
						patherr_set = 1'b1;
						rsp_err_d = 1'b1;
					end else if (space_bad) begin
						rsp_err_d = 1'b1;
					end else begin
						lock_d = 1'b1;
						lpath_d = req_path;
						if (req_fn != 3'h0) begin
							fu_fn_d = req_fn;
							fu_addr_d = req_addr;
							fu_write_d = req_write;
							fu_wdata_d = req_wdata;
							state_d = fzr_pkg::ST_FU;
						end else if (!req_write) begin
							rsp_rdata_d = rd_byte;
						end else if (dif.region == fzr_pkg::REG_CCCR) begin
							case (req_addr[7:0])
								fzr_pkg::CC_IOEN: ioen_d = req_wdata[7:1];
								fzr_pkg::CC_INTEN: inten_d = ext ? inten_q : req_wdata;
								fzr_pkg::CC_ABORT: begin
									card_res = req_wdata[fzr_pkg::ABORT_RES_BIT];
									if (req_wdata[2:0] != 3'h0) begin
										abort_d[req_wdata[2:0]] = 1'b1;
									end
								end
								fzr_pkg::CC_BUSIF: busif_d = req_wdata & fzr_pkg::BUSIF_WMASK;
								fzr_pkg::CC_PWR: pwr_d = req_wdata & fzr_pkg::PWR_WMASK;
								default: ;
							endcase
						end
					end
				end
			end
			fzr_pkg::ST_FU: begin
				if (fu_rsp_valid) begin
					rsp_rdata_d = fu_rsp_rdata;
					state_d = fzr_pkg::ST_RSP;
				end
			end
			fzr_pkg::ST_RSP: state_d = fzr_pkg::ST_IDLE;
			default: state_d = fzr_pkg::ST_IDLE;
		endcase
		// card reset also releases the path choice
		if (card_res) begin
			ioen_d = '0;
			inten_d = '0;
			busif_d = '0;
			pwr_d = '0;
			lock_d = 1'b0;
		end
		// sticky flags: a new event beats a same-cycle clear
		patherr_d = (patherr_q && !stat_clr[fzr_pkg::ST_PATHERR_BIT]) || patherr_set;
		orderr_d = (orderr_q && !stat_clr[fzr_pkg::ST_ORDERR_BIT]) || (switch_func && |ioen_q);
		to_d = (to_q & ~stat_clr[fzr_pkg::ST_TO_LSB+:7]) | timer_exp;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= fzr_pkg::ST_IDLE;
			ioen_q <= '0;
			inten_q <= fzr_pkg::RST_BYTE;
			busif_q <= fzr_pkg::RST_BYTE;
			pwr_q <= fzr_pkg::RST_BYTE;
			abort_q <= '0;
			lock_q <= 1'b0;
			lpath_q <= 1'b0;
			patherr_q <= 1'b0;
			orderr_q <= 1'b0;
			to_q <= '0;
			rsp_rdata_q <= fzr_pkg::RST_BYTE;
			rsp_err_q <= 1'b0;
			fu_fn_q <= '0;
			fu_addr_q <= '0;
			fu_write_q <= 1'b0;
			fu_wdata_q <= fzr_pkg::RST_BYTE;
		end else begin
			state_q <= state_d;
			ioen_q <= ioen_d;
			inten_q <= inten_d;
			busif_q <= busif_d;
			pwr_q <= pwr_d;
			abort_q <= abort_d;
			lock_q <= lock_d;
			lpath_q <= lpath_d;
			patherr_q <= patherr_d;
			orderr_q <= orderr_d;
			to_q <= to_d;
			rsp_rdata_q <= rsp_rdata_d;
			rsp_err_q <= rsp_err_d;
			fu_fn_q <= fu_fn_d;
			fu_addr_q <= fu_addr_d;
			fu_write_q <= fu_write_d;
			fu_wdata_q <= fu_wdata_d;
		end
	end

	// software side
	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready = !w_got_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign axi_do_wr = aw_got_q && w_got_q;
	assign lock_clr = axi_do_wr && awaddr_q == fzr_pkg::AXI_CTRL && wdata_q[0];
	assign stat_clr = (axi_do_wr && awaddr_q == fzr_pkg::AXI_STAT) ? wdata_q : 32'h0;
	assign gi_we = axi_do_wr && gi_hit(awaddr_q);
	assign cis_we = axi_do_wr && cis_hit(awaddr_q);
	assign gi_widx = GIW'(awaddr_q - fzr_pkg::AXI_GI_BASE) & ~GIW'(3);
	assign cis_widx = CIW'(awaddr_q - fzr_pkg::AXI_CIS_BASE) & ~CIW'(3);
	assign gi_ridx = GIW'(s_axi_araddr - fzr_pkg::AXI_GI_BASE) & ~GIW'(3);
	assign cis_ridx = CIW'(s_axi_araddr - fzr_pkg::AXI_CIS_BASE) & ~CIW'(3);
	assign stat_word = {16'h0, to_q, 5'h00, orderr_q, patherr_q, lpath_q, lock_q};

	// words map onto bytes lowest lane first
	always_comb begin
		axi_rword = 32'h0;
		for (int k = 0; k < 4; k++) begin
			if (gi_hit(s_axi_araddr)) begin
				axi_rword[8*k+:8] = gi_mem[gi_ridx | GIW'(k)];
			end else if (cis_hit(s_axi_araddr)) begin
				axi_rword[8*k+:8] = cis_mem[cis_ridx | CIW'(k)];
			end
		end
		if (s_axi_araddr == fzr_pkg::AXI_STAT) begin
			axi_rword = stat_word;
		end
	end

	always_comb begin
		aw_got_d = aw_got_q || (s_axi_awvalid && s_axi_awready);
		w_got_d = w_got_q || (s_axi_wvalid && s_axi_wready);
		awaddr_d = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_q;
		wdata_d = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_q;
		wstrb_d = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (axi_do_wr) begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = (gi_we || cis_we || awaddr_q == fzr_pkg::AXI_CTRL ||
				awaddr_q == fzr_pkg::AXI_STAT) ? fzr_pkg::RESP_OKAY : fzr_pkg::RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rdata_d = axi_rword;
			rresp_d = (gi_hit(s_axi_araddr) || cis_hit(s_axi_araddr) ||
				s_axi_araddr == fzr_pkg::AXI_CTRL || s_axi_araddr == fzr_pkg::AXI_STAT) ?
				fzr_pkg::RESP_OKAY : fzr_pkg::RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= fzr_pkg::RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= fzr_pkg::RESP_OKAY;
		end else begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// content memories have no reset; firmware loads them after power-up
	always_ff @(posedge clk) begin
		for (int k = 0; k < 4; k++) begin
			if (gi_we && wstrb_q[k]) begin
				gi_mem[gi_widx | GIW'(k)] <= wdata_q[8*k+:8];
			end
			if (cis_we && wstrb_q[k]) begin
				cis_mem[cis_widx | CIW'(k)] <= wdata_q[8*k+:8];
			end
		end
	end

	property p_path_refuse;
		@(posedge clk) disable iff (!resetn)
		accept && path_bad |=> rsp_valid && rsp_err ##1 !rsp_valid;
	endproperty
	a_path_refuse: assert property (p_path_refuse) else $error("path switch not refused");
	property p_mem_space;
		@(posedge clk) disable iff (!resetn)
		accept && !path_bad && space_bad |=> rsp_valid && rsp_err && !fu_req_valid;
	endproperty
	a_mem_space: assert property (p_mem_space) else $error("memory space access served");
	property p_f0_answer;
		@(posedge clk) disable iff (!resetn)
		accept && !path_bad && !space_bad && req_fn == 3'h0 |=> rsp_valid && !rsp_err;
	endproperty
	a_f0_answer: assert property (p_f0_answer) else $error("function 0 access not answered");
	property p_fu_forward;
		@(posedge clk) disable iff (!resetn)
		accept && !path_bad && !space_bad && req_fn != 3'h0 |=>
			fu_req_valid && fu_fn == $past(req_fn) && fu_addr == $past(req_addr);
	endproperty
	a_fu_forward: assert property (p_fu_forward) else $error("unique space not forwarded");
	property p_lock_first;
		@(posedge clk) disable iff (!resetn)
		accept && !lock_q && !space_bad && !(req_write && req_fn == 3'h0 &&
			req_addr == {9'h000, fzr_pkg::CC_ABORT} && req_wdata[3]) |=>
			lock_q && lpath_q == $past(req_path);
	endproperty
	a_lock_first: assert property (p_lock_first) else $error("path not recorded");
	property p_card_res;
		@(posedge clk) disable iff (!resetn)
		accept && req_write && !path_bad && !space_bad && req_fn == 3'h0 &&
			req_addr == {9'h000, fzr_pkg::CC_ABORT} && req_wdata[3] |=> ioen_q == '0 && !lock_q;
	endproperty
	a_card_res: assert property (p_card_res) else $error("card reset ignored");
	property p_ext_inten;
		@(posedge clk) disable iff (!resetn)
		accept && ext && req_io_space && !path_bad && !req_write && req_fn == 3'h0 &&
			req_addr == {9'h000, fzr_pkg::CC_INTEN} |=> rsp_rdata == 8'h00;
	endproperty
	a_ext_inten: assert property (p_ext_inten) else $error("reduced set shows interrupts");
	property p_timeout_flag;
		@(posedge clk) disable iff (!resetn)
		|timer_exp |=> (to_q & $past(timer_exp)) == $past(timer_exp);
	endproperty
	a_timeout_flag: assert property (p_timeout_flag) else $error("timeout not latched");
	property p_axi_b;
		@(posedge clk) disable iff (!resetn)
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
	endproperty
	a_axi_b: assert property (p_axi_b) else $error("write response late");
endmodule
`default_nettype wire

// >>> tb/fzr_fn_model.sv
// Purpose: function-side responder and ready source
// Assumes: fu requests are held until answered
// Notes: odd addresses answer slowly; writes echo their data; fn1 never comes ready
`timescale 1ns/1ps
`default_nettype none
module fzr_fn_model #(
	parameter logic [7:1] RDY_MASK = 7'h7e
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic fu_req_valid,
	input wire logic [2:0] fu_fn,
	input wire logic [16:0] fu_addr,
	input wire logic fu_write,
	input wire logic [7:0] fu_wdata,
	input wire logic [7:1] io_enable,
	output logic fu_rsp_valid,
	output logic [7:0] fu_rsp_rdata,
	output logic [7:1] fn_ready
);
	logic [2:0] cnt_q;
	logic [7:1] en_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 3'h0;
			en_q <= 7'h00;
			fn_ready <= 7'h00;
			fu_rsp_valid <= 1'b0;
			fu_rsp_rdata <= 8'h00;
		end else begin
			fu_rsp_valid <= 1'b0;
			// idle data toggles so a late sample is caught
			fu_rsp_rdata <= ~fu_rsp_rdata;
			en_q <= io_enable;
			fn_ready <= en_q & io_enable & RDY_MASK;
			if (fu_req_valid && !fu_rsp_valid) begin
				if (cnt_q == (fu_addr[0] ? 3'h5 : 3'h0)) begin
					fu_rsp_valid <= 1'b1;
					fu_rsp_rdata <= fu_write ? fu_wdata : fu_addr[7:0] ^ {5'h00, fu_fn};
					cnt_q <= 3'h0;
				end else begin
					cnt_q <= cnt_q + 3'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/fzr_bench.sv
// Purpose: self-checking bench of the function 0 register space
// Assumes: short ready timeout of 20 cycles
// Notes: host commands and AXI4-Lite accesses are sequential
`timescale 1ns/1ps
`default_nettype none
module fzr_bench;
	logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, sw, fu_v, fu_r, fu_wr, em;
	logic req_valid, req_ready, req_path, req_io, req_write, rsp_valid, rsp_err;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d32;
	logic [1:0] bresp, rresp, r2, bw;
	logic [2:0] req_fn, fu_fn;
	logic [16:0] req_addr, fu_addr;
	logic [7:0] req_wdata, rsp_rdata, fu_d, fu_wd;
	logic [7:1] fn_ready, io_en, abt;
	logic [4:0] hs;
	logic [3:0] ws;
	int bad_count, num_checks;
	assign hs = {rsp_valid, req_ready, rvalid, arready, bvalid};
	fzr_top #(.READY_TO_CYC(20), .REV_VAL(8'h32), .CAP_VAL(8'h5a), .FBR_CODE_VAL(8'h0e),
		.SMPC_VAL(1'b1)) dut_u (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(ws), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .req_valid(req_valid), .req_ready(req_ready),
		.req_path(req_path), .req_io_space(req_io), .req_write(req_write),
		.req_fn(req_fn), .req_addr(req_addr), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err),
		.fu_req_valid(fu_v), .fu_fn(fu_fn), .fu_addr(fu_addr), .fu_write(fu_wr),
		.fu_wdata(fu_wd), .fu_rsp_valid(fu_r), .fu_rsp_rdata(fu_d), .fn_ready(fn_ready),
		.switch_func(sw), .io_enable(io_en), .fn_abort(abt), .bus_width(bw), .empc(em));
	fzr_fn_model fn_u (.clk(clk), .resetn(resetn), .fu_req_valid(fu_v), .fu_fn(fu_fn),
		.fu_addr(fu_addr), .fu_write(fu_wr), .fu_wdata(fu_wd), .io_enable(io_en),
		.fu_rsp_valid(fu_r),
		.fu_rsp_rdata(fu_d), .fn_ready(fn_ready));
	task report_and_stop;
		if (bad_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// wait at the falling edge, where outputs are settled; the watchdog ends a hang
	task wneg(input int k);
		do
			@(negedge clk);
		while (hs[k] !== 1'b1);
	endtask
	task axw(input logic [15:0] a, input logic [31:0] d);
		logic ak, wk;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ak = 1'b0;
		wk = 1'b0;
		while (!(ak && wk)) begin
			@(negedge clk);
			ak = ak | awready;
			wk = wk | wready;
			@(posedge clk);
			if (ak) awvalid <= 1'b0;
			if (wk) wvalid <= 1'b0;
		end
		wneg(0);
		r2 = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask
	task axr(input logic [15:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		wneg(1);
		@(posedge clk);
		arvalid <= 1'b0;
		wneg(2);
		d32 = rdata;
		r2 = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask
	// data is only compared on error-free reads
	task h(input logic p, io, w, input logic [2:0] f, input logic [16:0] a,
		input logic [7:0] wd, input logic ee, input logic [7:0] ed);
		@(posedge clk);
		req_valid <= 1'b1;
		req_path <= p;
		req_io <= io;
		req_write <= w;
		req_fn <= f;
		req_addr <= a;
		req_wdata <= wd;
		wneg(3);
		@(posedge clk);
		req_valid <= 1'b0;
		wneg(4);
		chk({23'h0, rsp_err, (w || ee) ? 8'h00 : rsp_rdata}, {23'h0, ee, (w || ee) ? 8'h00 : ed});
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		report_and_stop;
	end
	initial begin
		resetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, req_valid, sw} = 7'h00;
		{req_path, req_io, req_write, req_fn, req_addr, req_wdata} = 31'h0;
		{awaddr, araddr, wdata} = 64'h0;
		ws = 4'hf;
		bad_count = 0;
		num_checks = 0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		chk({25'h0, io_en}, 32'h0);
		axw(fzr_pkg::AXI_GI_BASE, 32'h12345678);
		chk({30'h0, r2}, 32'h0);
		axw(fzr_pkg::AXI_CIS_BASE, 32'h000000a5);
		ws <= 4'h2;
		axw(fzr_pkg::AXI_CIS_BASE, 32'hffff5aff);
		ws <= 4'hf;
		axr(fzr_pkg::AXI_CIS_BASE);
		chk(d32, 32'h00005aa5);
		axr(fzr_pkg::AXI_GI_BASE);
		chk(d32, 32'h12345678);
		axr(16'h0400);
		chk({r2, d32[29:0]}, {fzr_pkg::RESP_SLVERR, 30'h0});
		for (int i = 0; i < 4; i++)
			h(0, 0, 0, 0, 17'h00800 + 17'(i), 0, 0, 8'(32'h12345678 >> (8 * i)));
		h(0, 0, 0, 0, 17'h00c00, 0, 0, 8'h00);
		h(0, 0, 0, 0, 17'h01000, 0, 0, 8'ha5);
		for (int i = 0; i < 3; i++)
			h(0, 0, 0, 0, 17'h00009 + 17'(i), 0, 0, (i == 1) ? 8'h10 : 8'h00);
		h(0, 0, 0, 0, 17'h00100, 0, 0, 8'h0e);
		h(0, 0, 0, 0, 17'h00008, 0, 0, 8'h5a);
		h(0, 0, 1, 0, 17'h00007, 8'hff, 0, 0);
		h(0, 0, 0, 0, 17'h00007, 0, 0, 8'h83);
		chk({30'h0, bw}, 32'h3);
		h(0, 0, 1, 0, 17'h00002, 8'h06, 0, 0);
		@(posedge clk);
		@(negedge clk);
		chk({25'h0, io_en}, 32'h3);
		repeat (40) @(posedge clk);
		h(0, 0, 0, 0, 17'h00003, 0, 0, 8'h04);
		@(posedge clk);
		sw <= 1'b1;
		@(posedge clk);
		sw <= 1'b0;
		h(0, 0, 0, 3, 17'h1ffff, 0, 0, 8'hfc);
		h(0, 0, 0, 7, 17'h00000, 0, 0, 8'h07);
		h(0, 0, 1, 5, 17'h00002, 8'h3c, 0, 0);
		chk({24'h0, rsp_rdata}, 32'h3c);
		h(1, 1, 0, 0, 17'h00000, 0, 1, 0);
		axr(fzr_pkg::AXI_STAT);
		chk({16'h0, d32[15:0] & 16'hfe0f}, 32'h020d);
		h(0, 0, 1, 0, 17'h00006, 8'h0a, 0, 0);
		chk({25'h0, abt}, 32'h2);
		@(posedge clk);
		@(negedge clk);
		chk({25'h0, io_en}, 32'h0);
		axw(fzr_pkg::AXI_CTRL, 32'h1);
		axw(fzr_pkg::AXI_STAT, 32'h0000fe0c);
		axr(fzr_pkg::AXI_STAT);
		chk(d32, 32'h0);
		h(1, 0, 0, 0, 17'h00000, 0, 1, 0);
		h(1, 1, 0, 0, 17'h00000, 0, 0, 8'h32);
		h(1, 1, 0, 0, 17'h00008, 0, 0, 8'h00);
		h(1, 1, 1, 0, 17'h00012, 8'hff, 0, 0);
		h(1, 1, 0, 0, 17'h00012, 0, 0, 8'h1f);
		chk({31'h0, em}, 32'h1);
		h(0, 0, 0, 0, 17'h00000, 0, 1, 0);
		axr(fzr_pkg::AXI_STAT);
		chk({30'h0, d32[1:0]}, 32'h3);
		axw(fzr_pkg::AXI_CTRL, 32'h1);
		h(0, 0, 0, 0, 17'h00000, 0, 0, 8'h32);
		h(0, 0, 1, 0, 17'h00004, 8'hff, 0, 0);
		h(0, 0, 0, 0, 17'h00004, 0, 0, 8'hff);
		axw(fzr_pkg::AXI_CTRL, 32'h1);
		h(1, 1, 0, 0, 17'h00004, 0, 0, 8'h00);
		report_and_stop;
	end
endmodule
`default_nettype wire
